/* gpio_port_mode_logic.sv */
// three 8-bit pin ports with per-pin mode, pin sampling and pin irqs
//
// The address-and-strobe port and the address map were left to the implementer.
`default_nettype none
`include "gpio_params.svh"

module gpio_port_mode_logic (
  // clock and reset
  input  wire logic           REF_CLK_I,
  input  wire logic           RST_B_I,
  // register port
  input  wire gpio_pkg::addr_t ADDR_I,
  input  wire gpio_pkg::byte_t WDATA_I,
  input  wire logic           WR_I,
  input  wire logic           RD_I,
  output var  gpio_pkg::byte_t RDATA_O,
  // pins
  input  wire gpio_pkg::pins_t PIN_IN_I,
  output var  gpio_pkg::pins_t PIN_OUT_O,
  output var  gpio_pkg::pins_t PIN_OE_O,
  // alternate functions
  input  wire gpio_pkg::pins_t ALT_OUT_I,
  input  wire gpio_pkg::pins_t ALT_OE_I,
  output var  gpio_pkg::pins_t ALT_IN_O,
  // per-pin interrupt requests
  output var  gpio_pkg::pins_t IRQ_O
);
  import gpio_pkg::*;

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic mode_t mode_of(input logic hi, input logic lo,
                                    input logic dir, input logic dat);
    mode_t m;
    m = MODE_IN;
    casez ({hi, lo, dir, dat})
      4'b000?: m = MODE_OUT;
      4'b001?: m = MODE_IN;
      4'b010?: m = MODE_OD;
      4'b011?: m = MODE_OS;
      4'b1000: m = MODE_RSVD;
      4'b1001: m = MODE_DUAL;
      4'b101?: m = MODE_ALT;
      4'b110?: m = MODE_LEVEL;
      default: m = MODE_SINGLE;
    endcase
    return m;
  endfunction

  function automatic logic is_edge(input mode_t m);
    return (m == MODE_DUAL) || (m == MODE_SINGLE);
  endfunction

  function automatic logic map_hit(input addr_t a);
    return a[3:2] != `PORT_NONE;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_t q;
  state_t d;
  pins_t  clr;
  pins_t  edg;
  pins_t  pin_out;
  pins_t  pin_oe;
  mode_t  modes [`PIN_W];

  always_comb begin
    int    port;
    logic  hit;
    logic  chg;
    logic  lvl;
    mode_t m;
    port = int'(ADDR_I[3:2]);
    hit = map_hit(ADDR_I);
    chg = 1'b0;
    lvl = 1'b0;
    m = MODE_IN;
    d = q;
    clr = '0;
    edg = '0;
    pin_out = '0;
    pin_oe = '0;
    // -------------------------------------------------------------
    // pin sampling
    // -------------------------------------------------------------
    // two-stage sampler, then one more stage for edge compare
    d.sync1 = PIN_IN_I;
    d.samp = q.sync1;
    d.prev = q.samp;

    // -------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------
    // data byte keeps what is written, even in edge modes, so that
    // mode 9 can still be switched between edges
    if (WR_I && hit) begin
      case (ADDR_I[1:0])
        `OFS_DATA:   d.pin_data_reg[port*`PORT_W +: `PORT_W] = WDATA_I;
        `OFS_DIR:    d.pin_direction_reg[port*`PORT_W +: `PORT_W] = WDATA_I;
        `OFS_ALT_LO: d.alt_select_low_reg[port*`PORT_W +: `PORT_W] = WDATA_I;
        default:     d.alt_select_high_reg[port*`PORT_W +: `PORT_W] = WDATA_I;
      endcase
    end

    // -------------------------------------------------------------
    // register reads
    // -------------------------------------------------------------
    // read data stand for one cycle only
    d.rdata = 8'h00;
    if (RD_I && hit) begin
      case (ADDR_I[1:0])
        `OFS_DATA:   d.rdata = q.samp[port*`PORT_W +: `PORT_W];
        `OFS_DIR:    d.rdata = q.pin_direction_reg[port*`PORT_W +: `PORT_W];
        `OFS_ALT_LO: d.rdata = q.alt_select_low_reg[port*`PORT_W +: `PORT_W];
        default:     d.rdata = q.alt_select_high_reg[port*`PORT_W +: `PORT_W];
      endcase
    end

    // -------------------------------------------------------------
    // per-pin mode logic
    // -------------------------------------------------------------
    for (int i = 0; i < `PIN_W; i++) begin
      m = modes[i];
      chg = q.samp[i] ^ q.prev[i];
      case (m)
        MODE_DUAL:   edg[i] = chg;
        MODE_SINGLE: edg[i] = chg && (q.samp[i] == q.pin_data_reg[i]);
        default:     edg[i] = 1'b0;
      endcase
      clr[i] = WR_I && hit && (ADDR_I[1:0] == `OFS_DATA) && (port == i / 8)
               && WDATA_I[i % 8] && is_edge(m);
      // a new edge in the clearing cycle wins over the clear
      d.pend[i] = is_edge(m) ? ((q.pend[i] && !clr[i]) || edg[i])
                             : 1'b0;
      // two successive samples at the selected level
      lvl = (m == MODE_LEVEL) && (q.samp[i] == q.pin_data_reg[i])
            && (q.prev[i] == q.pin_data_reg[i]);
      d.irq[i] = lvl || d.pend[i];
      case (m)
        MODE_OUT: begin
          pin_oe[i] = 1'b1;
          pin_out[i] = q.pin_data_reg[i];
        end
        MODE_OD: begin
          pin_oe[i] = !q.pin_data_reg[i];
          pin_out[i] = 1'b0;
        end
        MODE_OS: begin
          pin_oe[i] = q.pin_data_reg[i];
          pin_out[i] = 1'b1;
        end
        MODE_ALT: begin
          pin_oe[i] = ALT_OE_I[i];
          pin_out[i] = ALT_OUT_I[i];
        end
        default: begin
          // input, reserved and irq modes all float
          pin_oe[i] = 1'b0;
          pin_out[i] = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // per-pin mode decode
  // ---------------------------------------------------------------
  for (genvar g = 0; g < `PIN_W; g++) begin : g_mode
    assign modes[g] = mode_of(q.alt_select_high_reg[g],
                              q.alt_select_low_reg[g],
                              q.pin_direction_reg[g],
                              q.pin_data_reg[g]);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      q.pin_data_reg <= {`NUM_PORTS{`RST_DATA}};
      q.pin_direction_reg <= {`NUM_PORTS{`RST_DIR}};
      q.alt_select_low_reg <= {`NUM_PORTS{`RST_ALT_LO}};
      q.alt_select_high_reg <= {`NUM_PORTS{`RST_ALT_HI}};
      q.sync1 <= '0;
      q.samp <= '0;
      q.prev <= '0;
      q.pend <= '0;
      q.irq <= '0;
      q.rdata <= 8'h00;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // alt out/oe pass-through is combinational so the peripheral keeps its timing; alt in is the two-stage sample
  assign PIN_OUT_O = pin_out;
  assign PIN_OE_O = pin_oe;
  assign ALT_IN_O = q.samp;
  assign IRQ_O = q.irq;
  assign RDATA_O = q.rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  reset_quiet_a: assert property (
    $rose(RST_B_I) |-> (PIN_OE_O == '0) && (IRQ_O == '0))
    else $error("pins not quiet after reset");

  read_sampled_a: assert property (
    (RD_I && map_hit(ADDR_I) && ADDR_I[1:0] == `OFS_DATA)
    |=> RDATA_O == $past(q.samp[int'(ADDR_I[3:2])*`PORT_W +: `PORT_W]))
    else $error("data read not the sampled pins");

  read_stored_a: assert property (
    (RD_I && map_hit(ADDR_I) && ADDR_I[1:0] == `OFS_DIR)
    |=> RDATA_O
        == $past(q.pin_direction_reg[int'(ADDR_I[3:2])*`PORT_W +: `PORT_W]))
    else $error("direction read not the stored byte");

  dir_store_a: assert property (
    (WR_I && map_hit(ADDR_I) && ADDR_I[1:0] == `OFS_DIR)
    |=> q.pin_direction_reg[$past(int'(ADDR_I[3:2]))*`PORT_W +: `PORT_W]
        == $past(WDATA_I))
    else $error("direction write not stored");

  unmapped_zero_a: assert property (
    (RD_I && !map_hit(ADDR_I)) |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");

  rdata_idle_a: assert property (
    !RD_I |=> RDATA_O == 8'h00)
    else $error("read data outside read cycle");

  // ---------------------------------------------------------------
  // per-pin checks
  // ---------------------------------------------------------------
  for (genvar g = 0; g < `PIN_W; g++) begin : g_chk
    push_pull_a: assert property (
      modes[g] == MODE_OUT |-> PIN_OE_O[g] && PIN_OUT_O[g] == q.pin_data_reg[g])
      else $error("push-pull pin wrong");

    input_float_a: assert property (
      (modes[g] == MODE_IN || modes[g] == MODE_RSVD) |-> !PIN_OE_O[g])
      else $error("input pin driven");

    open_drain_a: assert property (
      modes[g] == MODE_OD |-> PIN_OE_O[g] == !q.pin_data_reg[g]
                              && !PIN_OUT_O[g])
      else $error("open-drain pin wrong");

    open_source_a: assert property (
      modes[g] == MODE_OS |-> PIN_OE_O[g] == q.pin_data_reg[g]
                              && PIN_OUT_O[g])
      else $error("open-source pin wrong");

    alt_owns_a: assert property (
      modes[g] == MODE_ALT |-> PIN_OE_O[g] == ALT_OE_I[g]
                               && PIN_OUT_O[g] == ALT_OUT_I[g])
      else $error("alternate function not in control");

    irq_float_a: assert property (
      (is_edge(modes[g]) || modes[g] == MODE_LEVEL) |-> !PIN_OE_O[g])
      else $error("irq pin driven");

    sample_delay_a: assert property (
      $past(RST_B_I, 3) |-> ALT_IN_O[g] == $past(PIN_IN_I[g], 2))
      else $error("sampled pin not two clocks late");

    level_hold_a: assert property (
      (modes[g] == MODE_LEVEL && $stable(q.pin_data_reg[g])
       && q.samp[g] == q.pin_data_reg[g] && q.prev[g] == q.pin_data_reg[g])
      |=> IRQ_O[g])
      else $error("level irq missing");

    level_cause_a: assert property (
      (IRQ_O[g] && $past(modes[g]) == MODE_LEVEL)
      |-> $past(q.samp[g]) == $past(q.pin_data_reg[g])
          && $past(q.prev[g]) == $past(q.pin_data_reg[g]))
      else $error("level irq without two matching samples");

    level_drop_a: assert property (
      (modes[g] == MODE_LEVEL && q.samp[g] != q.pin_data_reg[g])
      |=> !IRQ_O[g])
      else $error("level irq outlives its level");

    dual_edge_a: assert property (
      (modes[g] == MODE_DUAL && q.samp[g] != q.prev[g]) |=> IRQ_O[g])
      else $error("dual edge irq missing");

    single_rise_a: assert property (
      (modes[g] == MODE_SINGLE && q.pin_data_reg[g]
       && q.samp[g] && !q.prev[g]) |=> IRQ_O[g])
      else $error("rising edge irq missing");

    single_fall_a: assert property (
      (modes[g] == MODE_SINGLE && !q.pin_data_reg[g]
       && !q.samp[g] && q.prev[g]) |=> IRQ_O[g])
      else $error("falling edge irq missing");

    single_wrong_a: assert property (
      (modes[g] == MODE_SINGLE && !q.pend[g]
       && q.samp[g] != q.pin_data_reg[g]) |=> !IRQ_O[g])
      else $error("irq on the unselected edge");

    edge_sticky_a: assert property (
      (is_edge(modes[g]) && q.pend[g] && !clr[g]
       && $stable(q.alt_select_high_reg[g]))
      ##1 is_edge(modes[g]) |-> IRQ_O[g])
      else $error("edge irq dropped without clear");

    edge_clear_a: assert property (
      (clr[g] && !edg[g]) |=> !IRQ_O[g])
      else $error("edge irq not cleared by write of one");

    write_zero_a: assert property (
      (is_edge(modes[g]) && q.pend[g] && WR_I && map_hit(ADDR_I)
       && ADDR_I[1:0] == `OFS_DATA && int'(ADDR_I[3:2]) == g / 8
       && !WDATA_I[g % 8]) |=> IRQ_O[g])
      else $error("write of zero cleared edge irq");

    edge_wins_a: assert property (
      (clr[g] && edg[g]) |=> IRQ_O[g])
      else $error("edge lost in clearing cycle");

    no_irq_idle_a: assert property (
      (modes[g] == MODE_IN || modes[g] == MODE_OUT) |=> !q.pend[g])
      else $error("edge latch held outside edge modes");

    irq_off_a: assert property (
      modes[g] == MODE_IN |=> !IRQ_O[g])
      else $error("irq from an input pin");
  end

  // ---------------------------------------------------------------
  // scenario covers
  // ---------------------------------------------------------------
  level_irq_c: cover property (modes[0] == MODE_LEVEL ##1 IRQ_O[0]);
  dual_irq_c: cover property (modes[9] == MODE_DUAL && edg[9]);
  single_irq_c: cover property (modes[17] == MODE_SINGLE && edg[17]);
  clear_c: cover property (clr[3] ##1 !IRQ_O[3]);
  alt_c: cover property (modes[5] == MODE_ALT && PIN_OE_O[5]);

endmodule

`default_nettype wire

/* gpio_params.svh */
// constants for the three-port pin mode logic
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// ---------------------------------------------------------------
// geometry
// ---------------------------------------------------------------
`define NUM_PORTS  3
`define PORT_W     8
`define PIN_W      24
`define ADDR_W     4

// ---------------------------------------------------------------
// register offsets: addr[3:2] picks the port, addr[1:0] the register
// ---------------------------------------------------------------
`define OFS_DATA   2'h0
`define OFS_DIR    2'h1
`define OFS_ALT_LO 2'h2
`define OFS_ALT_HI 2'h3
`define PORT_NONE  2'h3

// ---------------------------------------------------------------
// reset values per port byte
// ---------------------------------------------------------------
`define RST_DATA   8'h00
`define RST_DIR    8'hff
`define RST_ALT_LO 8'h00
`define RST_ALT_HI 8'h00

`endif

/* gpio_pkg.sv */
// types for the three-port pin mode logic
`default_nettype none
`include "gpio_params.svh"

package gpio_pkg;

  // -------------------------------------------------------------
  // pin modes
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OUT    = 4'h1,
    MODE_IN     = 4'h2,
    MODE_OD     = 4'h3,
    MODE_OS     = 4'h4,
    MODE_RSVD   = 4'h5,
    MODE_DUAL   = 4'h6,
    MODE_ALT    = 4'h7,
    MODE_LEVEL  = 4'h8,
    MODE_SINGLE = 4'h9
  } mode_t;

  typedef logic [`PIN_W-1:0]  pins_t;
  typedef logic [`PORT_W-1:0] byte_t;
  typedef logic [`ADDR_W-1:0] addr_t;

  // -------------------------------------------------------------
  // whole state of the block
  // -------------------------------------------------------------
  typedef struct packed {
    pins_t pin_data_reg;
    pins_t pin_direction_reg;
    pins_t alt_select_low_reg;
    pins_t alt_select_high_reg;
    pins_t sync1;
    pins_t samp;
    pins_t prev;
    pins_t pend;
    pins_t irq;
    byte_t rdata;
  } state_t;

endpackage

`default_nettype wire

/* gpio_pins_model.sv */
// external devices and resistors on the 24 pins
`default_nettype none

module gpio_pins_model (
  // design side
  input  wire gpio_pkg::pins_t drv_i,
  input  wire gpio_pkg::pins_t oe_i,
  // far side
  input  wire gpio_pkg::pins_t ext_i,
  input  wire gpio_pkg::pins_t ext_oe_i,
  input  wire gpio_pkg::pins_t pull_i,
  output var  gpio_pkg::pins_t wire_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_pkg::*;
  // ---------------------------------------------------------
  // wire resolution
  // ---------------------------------------------------------
  // pins released by both sides sit at the resistor level, never a stale value
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (oe_i[i])
        wire_o[i] = drv_i[i];
      else if (ext_oe_i[i])
        wire_o[i] = ext_i[i];
      else
        wire_o[i] = pull_i[i];
    end
  end
endmodule

`default_nettype wire

/* test_gpio_port_mode_logic.sv */
// self-checking bench for the pin mode logic
`default_nettype none

module test_gpio_port_mode_logic;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_pkg::*;
  // ---------------------------------------------------------
  // signals
  // ---------------------------------------------------------
  logic  clk, rst_b, wr, rd;
  addr_t addr;
  byte_t wdata, rdata, eo, ev, ew;
  pins_t pin_in, pin_out, pin_oe, alt_in, irq;
  pins_t alt_out, alt_oe, ext, ext_oe, pull;
  int    n_errors, comparisons, cycles;

  gpio_port_mode_logic uut (.REF_CLK_I(clk), .RST_B_I(rst_b),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out),
    .PIN_OE_O(pin_oe), .ALT_OUT_I(alt_out), .ALT_OE_I(alt_oe),
    .ALT_IN_O(alt_in), .IRQ_O(irq));
  gpio_pins_model pins (.drv_i(pin_out), .oe_i(pin_oe), .ext_i(ext),
    .ext_oe_i(ext_oe), .pull_i(pull), .wire_o(pin_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles used
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------
  // tasks
  // ---------------------------------------------------------
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic byte_t pb(pins_t v, int p);
    return v[p*8 +: 8];
  endfunction
  function automatic byte_t wire_b(int p);
    return (pb(ext_oe, p) & pb(ext, p)) | (~pb(ext_oe, p) & pb(pull, p));
  endfunction
  task automatic chk(string what, byte_t exp, byte_t got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(addr_t a, byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(string what, addr_t a, byte_t exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  // data goes first so edge modes start from a set bit
  task automatic set_port(addr_t b, byte_t d, byte_t dr, byte_t lo,
                          byte_t hi);
    wr_reg(b, d);
    wr_reg(b + 4'h1, dr);
    wr_reg(b + 4'h2, lo);
    wr_reg(b + 4'h3, hi);
    idle(3);
  endtask
  task automatic drive(byte_t v);
    @(posedge clk);
    ext[23:16] <= v;
    idle(5);
  endtask
  task automatic apply_reset();
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    idle(3);
    for (int p = 0; p < 3; p++) begin
      chk("oe", 8'h00, pb(pin_oe, p));
      chk("irq", 8'h00, pb(irq, p));
      rd_reg("data", addr_t'(p*4), wire_b(p));
      rd_reg("dir", addr_t'(p*4+1), 8'hff);
      rd_reg("alt_lo", addr_t'(p*4+2), 8'h00);
      rd_reg("alt_hi", addr_t'(p*4+3), 8'h00);
    end
    $display("test reset done");
  endtask
  // ---------------------------------------------------------
  // tests
  // ---------------------------------------------------------
  initial begin
    {rst_b, wr, rd, addr, wdata, ext, n_errors, comparisons} = '0;
    alt_out = 24'h003c00;
    alt_oe = 24'h005a00;
    ext_oe = 24'hff0000;
    pull = 24'h96a5c3;
    apply_reset();
    for (int m = 0; m < 16; m++) begin
      set_port(4'h4, {8{m[0]}}, {8{m[1]}}, {8{m[2]}}, {8{m[3]}});
      eo = (m < 2 || m == 4 || m == 7) ? 8'hff :
           (m == 10 || m == 11) ? pb(alt_oe, 1) : 8'h00;
      ev = (m == 10 || m == 11) ? pb(alt_out, 1) :
           (m == 1 || m == 7) ? 8'hff : 8'h00;
      ew = (eo & ev) | (~eo & pb(pull, 1));
      chk("oe1", eo, pb(pin_oe, 1));
      chk("out1", ev & eo, pb(pin_out, 1) & eo);
      chk("oe0", 8'h00, pb(pin_oe, 0));
      rd_reg("data1", 4'h4, ew);
      chk("alt_in1", ew, pb(alt_in, 1));
    end
    $display("test modes done");
    wr_reg(4'hd, 8'h00);
    rd_reg("unmapped", 4'hd, 8'h00);
    rd_reg("dir0", 4'h1, 8'hff);
    set_port(4'h8, 8'hff, 8'h00, 8'h00, 8'hff);
    wr_reg(4'h8, 8'hff);
    idle(2);
    chk("dual clr", 8'h00, pb(irq, 2));
    drive(8'h0f);
    chk("dual rise", 8'h0f, pb(irq, 2));
    wr_reg(4'h8, 8'hff);
    idle(2);
    chk("dual clr2", 8'h00, pb(irq, 2));
    drive(8'h00);
    chk("dual fall", 8'h0f, pb(irq, 2));
    set_port(4'h8, 8'hff, 8'hff, 8'hff, 8'hff);
    wr_reg(4'h8, 8'hff);
    drive(8'hf0);
    chk("rise", 8'hf0, pb(irq, 2));
    drive(8'h00);
    chk("latched", 8'hf0, pb(irq, 2));
    wr_reg(4'h8, 8'h0f);
    wr_reg(4'h8, 8'h00);
    idle(2);
    chk("write 0", 8'hf0, pb(irq, 2));
    wr_reg(4'h8, 8'hff);
    wr_reg(4'h8, 8'h00);
    drive(8'hff);
    chk("no rise", 8'h00, pb(irq, 2));
    drive(8'h00);
    chk("fall", 8'hff, pb(irq, 2));
    $display("test edges done");
    set_port(4'h8, 8'h0f, 8'h00, 8'hff, 8'hff);
    chk("level lo", 8'hf0, pb(irq, 2));
    drive(8'hff);
    chk("level hi", 8'h0f, pb(irq, 2));
    @(posedge clk);
    ext[23:16] <= 8'h00;
    @(posedge clk);
    ext[23:16] <= 8'hff;
    repeat (6) begin
      idle(1);
      chk("glitch", 8'h00, pb(irq, 2) & 8'hf0);
    end
    chk("level held", 8'h0f, pb(irq, 2));
    $display("test level done");
    apply_reset();
    end_of_test();
  end
endmodule

`default_nettype wire
